// ### hw/cgpol_top.sv
/*
 * Clock gating and low-power clock policy: gate registers, access faults,
 * reference and mode limits, power-mode tracking and the 1 kHz clock.
 * Assumes an AXI4-Lite master, a peripheral access port and a boot strap pin.
 */
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module cgpol_top
    import cgpol_pkg::*;
#(
    parameter int unsigned LPO_HALF_CYCLES = LPO_HALF_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic PERIPH_REQ,
    input wire logic [4:0] PERIPH_SEL,
    output logic PERIPH_ACK,
    output logic HARD_FAULT,
    input wire logic LOW_POWER_BOOT_OPTION_PIN,
    output logic [NUM_GATES-1:0] MOD_CLK,
    output logic PLL_REF_SEL,
    output logic [1:0] FLL_REF_SEL,
    output logic [1:0] OUT_CLK_SEL,
    output logic [2:0] GEN_MODE,
    output logic [3:0] CORE_DIV,
    output logic [3:0] BUS_DIV,
    output logic PLL_PATH_EN,
    output logic FLL_PATH_EN,
    output logic USB_FAST_IRC,
    output logic [1:0] PWR_MODE,
    output logic REG_ACTIVE,
    output logic FREQ_LIMIT,
    output logic LPO_CLK
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic aw_have_q, w_have_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;
    logic wr_en, wr_full, wr_hit;
    logic [7:0] araddr;

    assign wr_en = aw_have_q && w_have_q && !bvalid_q;
    assign wr_full = wstrb_q == 4'hf;
    assign wr_hit = (awaddr_q < OFS_GATE0 + 8'(4 * GATE_REGS)) || (awaddr_q >= OFS_SRCSEL && awaddr_q <= OFS_STATUS);
    assign araddr = S_AXI_ARADDR[7:0];

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
        end else begin
            if (S_AXI_AWVALID && awready_q) begin
                awaddr_q <= (S_AXI_AWADDR[31:8] == 24'h0) ? {S_AXI_AWADDR[7:2], 2'b00} : 8'hfc;
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
            end
            if (S_AXI_WVALID && wready_q) begin
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
            end
            if (wr_en) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_hit ? 2'b00 : 2'b10;
            end
            if (bvalid_q && S_AXI_BREADY) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // Register writes act only on full-word strobes
    logic wr_gate, wr_src, wr_gm, wr_div, wr_path, wr_pm, wr_st;
    assign wr_gate = wr_en && wr_full && awaddr_q < OFS_GATE0 + 8'(4 * GATE_REGS);
    assign wr_src = wr_en && wr_full && awaddr_q == OFS_SRCSEL;
    assign wr_gm = wr_en && wr_full && awaddr_q == OFS_GENMODE;
    assign wr_div = wr_en && wr_full && awaddr_q == OFS_SYSDIV;
    assign wr_path = wr_en && wr_full && awaddr_q == OFS_PATHCTL;
    assign wr_pm = wr_en && wr_full && awaddr_q == OFS_PMREQ;
    assign wr_st = wr_en && wr_full && awaddr_q == OFS_STATUS;

    // ------------------------------------------------------------
    // Gate registers and module clocks
    // ------------------------------------------------------------
    logic [NUM_GATES-1:0] gate_q;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_GATES; gi++) begin : g_gate
            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    gate_q[gi] <= (gi == FLASH_GATE) ? GATE_LAST_RST[0] : GATE_RST[0];
                end else if (wr_gate && awaddr_q[4:2] == 3'(gi / GATES_PER_REG)) begin
                    gate_q[gi] <= wdata_q[gi % GATES_PER_REG];
                end
            end
            cgpol_clk_gate u_gate (
                .clk(CLK),
                .rst_n(RST_N),
                .en(gate_q[gi]),
                .clk_out(MOD_CLK[gi])
            );
        end
    endgenerate

    // Peripheral access checked against its gate
    logic periph_ack_q, hard_fault_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            periph_ack_q <= 1'b0;
            hard_fault_q <= 1'b0;
        end else begin
            periph_ack_q <= PERIPH_REQ && PERIPH_SEL < 5'(NUM_GATES) && gate_q[PERIPH_SEL];
            hard_fault_q <= PERIPH_REQ && !(PERIPH_SEL < 5'(NUM_GATES) && gate_q[PERIPH_SEL]);
        end
    end

    // ------------------------------------------------------------
    // Boot option strap
    // ------------------------------------------------------------
    logic [2:0] boot_sync_q;
    logic [1:0] boot_cnt_q;
    logic low_power_boot_option_q, boot_apply;
    always_ff @(posedge CLK) begin
        boot_sync_q <= {boot_sync_q[1:0], LOW_POWER_BOOT_OPTION_PIN};
        if (!RST_N) begin
            boot_cnt_q <= 2'd0;
            low_power_boot_option_q <= 1'b0;
        end else begin
            if (boot_cnt_q != 2'(BOOT_SETTLE_CYC)) begin
                boot_cnt_q <= boot_cnt_q + 2'd1;
            end
            if (boot_apply) begin
                low_power_boot_option_q <= boot_sync_q[2];
            end
        end
    end
    assign boot_apply = boot_cnt_q == 2'(BOOT_SETTLE_CYC - 1) && boot_sync_q[1] == boot_sync_q[2];

    // ------------------------------------------------------------
    // Power mode
    // ------------------------------------------------------------
    cgpol_pmode_t pmode_q, req_mode;
    cgpol_gmode_t gmode_q;
    logic very_low_power_stop_from_run_q, gm_low, pm_ok;
    assign req_mode = cgpol_pmode_t'(wdata_q[1:0]);
    assign gm_low = gmode_q == GM_BYP_LP_EXT || gmode_q == GM_BYP_LP_INT || gmode_q == GM_SLOW_IRC;

    always_comb begin
        pm_ok = 1'b1;
        unique case (pmode_q)
            PM_RUN: pm_ok = req_mode != PM_VERY_LOW_POWER_WAIT && (req_mode != PM_VERY_LOW_POWER_RUN || gm_low);
            PM_VERY_LOW_POWER_RUN: pm_ok = 1'b1;
            PM_VERY_LOW_POWER_WAIT: pm_ok = req_mode != PM_VERY_LOW_POWER_STOP;
            PM_VERY_LOW_POWER_STOP: pm_ok = req_mode != PM_VERY_LOW_POWER_WAIT && !(req_mode == PM_VERY_LOW_POWER_RUN && (very_low_power_stop_from_run_q || !gm_low));
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pmode_q <= PM_RUN;
            very_low_power_stop_from_run_q <= 1'b0;
        end else if (boot_apply && boot_sync_q[2]) begin
            pmode_q <= PM_VERY_LOW_POWER_RUN;
        end else if (wr_pm && pm_ok) begin
            pmode_q <= req_mode;
            if (req_mode == PM_VERY_LOW_POWER_STOP) begin
                very_low_power_stop_from_run_q <= pmode_q == PM_RUN;
            end
        end
    end

    // ------------------------------------------------------------
    // Clock generator controls
    // ------------------------------------------------------------
    logic [5:0] src_q;
    logic [3:0] core_div_q, bus_div_q;
    logic [2:0] path_q;
    logic src_ok, gm_ok, div_ok, vlp;
    cgpol_gmode_t gm_req;
    assign vlp = pmode_q == PM_VERY_LOW_POWER_RUN || pmode_q == PM_VERY_LOW_POWER_WAIT;
    assign gm_req = cgpol_gmode_t'(wdata_q[2:0]);
    assign src_ok = !wdata_q[SRC_PLL_INT];
    assign gm_ok = wdata_q[2:0] <= 3'(GM_FAST_IRC) && (HAS_FAST_IRC || gm_req != GM_FAST_IRC)
        && (!vlp || gm_req == GM_BYP_LP_EXT || gm_req == GM_BYP_LP_INT || gm_req == GM_SLOW_IRC);
    assign div_ok = pmode_q == PM_RUN;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            src_q <= SRCSEL_RST;
        end else if (wr_src && src_ok) begin
            src_q <= {wdata_q[SRC_OUT_LSB+:2], wdata_q[SRC_FLL_LSB+:2], 1'b0, wdata_q[SRC_PLL_REF]};
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            gmode_q <= GM_FLL_INT;
        end else if (boot_apply && boot_sync_q[2]) begin
            gmode_q <= GM_SLOW_IRC;
        end else if (wr_gm && gm_ok) begin
            gmode_q <= gm_req;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            core_div_q <= DIV_RST;
            bus_div_q <= DIV_RST;
        end else if (boot_apply && boot_sync_q[2]) begin
            core_div_q <= DIV_LOW_POWER_BOOT_OPTION;
            bus_div_q <= DIV_LOW_POWER_BOOT_OPTION;
        end else if (wr_div && div_ok) begin
            core_div_q <= wdata_q[DIV_CORE_LSB+:4];
            bus_div_q <= wdata_q[DIV_BUS_LSB+:4];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            path_q <= PATH_RST;
        end else if (wr_path) begin
            path_q <= {wdata_q[PATH_USB_FIRC] & HAS_FAST_IRC, wdata_q[PATH_FLL], wdata_q[PATH_PLL]};
        end
    end

    // Sticky errors; a new event wins over a clear in the same cycle
    logic ref_err_q, div_err_q, mode_err_q, trans_err_q, fault_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ref_err_q <= 1'b0;
            div_err_q <= 1'b0;
            mode_err_q <= 1'b0;
            trans_err_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            ref_err_q <= (wr_src && !src_ok) || (ref_err_q && !(wr_st && wdata_q[ST_REF_ERR]));
            div_err_q <= (wr_div && !div_ok) || (div_err_q && !(wr_st && wdata_q[ST_DIV_ERR]));
            mode_err_q <= (wr_gm && !gm_ok) || (mode_err_q && !(wr_st && wdata_q[ST_MODE_ERR]));
            trans_err_q <= (wr_pm && !pm_ok) || (trans_err_q && !(wr_st && wdata_q[ST_TRANS_ERR]));
            fault_q <= hard_fault_q || (fault_q && !(wr_st && wdata_q[ST_FAULT]));
        end
    end

    // ------------------------------------------------------------
    // Low-power 1 kHz clock, never stopped by any mode
    // ------------------------------------------------------------
    logic [31:0] lpo_cnt_q;
    logic lpo_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            lpo_cnt_q <= 32'h0;
            lpo_q <= 1'b0;
        end else if (lpo_cnt_q == LPO_HALF_CYCLES - 1) begin
            lpo_cnt_q <= 32'h0;
            lpo_q <= !lpo_q;
        end else begin
            lpo_cnt_q <= lpo_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic [31:0] rd_word;
    logic rd_hit;
    always_comb begin
        rd_word = 32'h0;
        rd_hit = 1'b1;
        if (araddr < OFS_GATE0 + 8'(4 * GATE_REGS)) begin
            rd_word[GATES_PER_REG-1:0] = gate_q[araddr[4:2]*GATES_PER_REG+:GATES_PER_REG];
        end else if (araddr == OFS_SRCSEL) begin
            rd_word[5:0] = src_q;
        end else if (araddr == OFS_GENMODE) begin
            rd_word[2:0] = gmode_q;
        end else if (araddr == OFS_SYSDIV) begin
            rd_word[7:0] = {bus_div_q, core_div_q};
        end else if (araddr == OFS_PATHCTL) begin
            rd_word[2:0] = path_q;
        end else if (araddr == OFS_PMREQ) begin
            rd_word[1:0] = pmode_q;
        end else if (araddr == OFS_STATUS) begin
            rd_word[ST_PMODE_LSB+:2] = pmode_q;
            rd_word[ST_GMODE_LSB+:3] = gmode_q;
            rd_word[ST_FAULT:ST_REF_ERR] = {fault_q, trans_err_q, mode_err_q, div_err_q, ref_err_q};
            rd_word[ST_LOW_POWER_BOOT_OPTION] = low_power_boot_option_q;
        end else begin
            rd_hit = 1'b0;
        end
        if (S_AXI_ARADDR[31:8] != 24'h0) begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'b00;
        end else if (S_AXI_ARVALID && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_hit ? rd_word : 32'h0;
            rresp_q <= rd_hit ? 2'b00 : 2'b10;
        end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic reg_active_q, freq_limit_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            reg_active_q <= 1'b1;
            freq_limit_q <= 1'b0;
        end else begin
            reg_active_q <= pmode_q == PM_RUN;
            freq_limit_q <= pmode_q != PM_RUN;
        end
    end

    assign S_AXI_AWREADY = awready_q;
    assign S_AXI_WREADY = wready_q;
    assign S_AXI_BVALID = bvalid_q;
    assign S_AXI_BRESP = bresp_q;
    assign S_AXI_ARREADY = arready_q;
    assign S_AXI_RVALID = rvalid_q;
    assign S_AXI_RDATA = rdata_q;
    assign S_AXI_RRESP = rresp_q;
    assign PERIPH_ACK = periph_ack_q;
    assign HARD_FAULT = hard_fault_q;
    assign PLL_REF_SEL = src_q[0];
    assign FLL_REF_SEL = src_q[3:2];
    assign OUT_CLK_SEL = src_q[5:4];
    assign GEN_MODE = gmode_q;
    assign CORE_DIV = core_div_q;
    assign BUS_DIV = bus_div_q;
    assign PLL_PATH_EN = path_q[0];
    assign FLL_PATH_EN = path_q[1];
    assign USB_FAST_IRC = path_q[2];
    assign PWR_MODE = pmode_q;
    assign REG_ACTIVE = reg_active_q;
    assign FREQ_LIMIT = freq_limit_q;
    assign LPO_CLK = lpo_q;
endmodule

// ### hw/cgpol_pkg.sv
/*
 * Constants and types for the clock gating and low-power clock policy block.
 * Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package cgpol_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ = 100_000_000;
    localparam int unsigned LPO_FREQ_HZ = 1_000;
    localparam int unsigned LPO_HALF_CYC = CLK_FREQ_HZ / (2 * LPO_FREQ_HZ);
    localparam int unsigned BOOT_SETTLE_CYC = 3;

    // ------------------------------------------------------------
    // Gates
    // ------------------------------------------------------------
    localparam int unsigned GATE_REGS = 7;
    localparam int unsigned GATES_PER_REG = 4;
    localparam int unsigned NUM_GATES = GATE_REGS * GATES_PER_REG;
    localparam logic [3:0] GATE_RST = 4'h0;
    localparam logic [3:0] GATE_LAST_RST = 4'h1;
    localparam int unsigned FLASH_GATE = NUM_GATES - GATES_PER_REG;
    localparam bit HAS_FAST_IRC = 1'b1;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_GATE0 = 8'h00;
    localparam logic [7:0] OFS_SRCSEL = 8'h20;
    localparam logic [7:0] OFS_GENMODE = 8'h24;
    localparam logic [7:0] OFS_SYSDIV = 8'h28;
    localparam logic [7:0] OFS_PATHCTL = 8'h2c;
    localparam logic [7:0] OFS_PMREQ = 8'h30;
    localparam logic [7:0] OFS_STATUS = 8'h34;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned SRC_PLL_REF = 0;
    localparam int unsigned SRC_PLL_INT = 1;
    localparam int unsigned SRC_FLL_LSB = 2;
    localparam int unsigned SRC_OUT_LSB = 4;
    localparam int unsigned DIV_CORE_LSB = 0;
    localparam int unsigned DIV_BUS_LSB = 4;
    localparam int unsigned PATH_PLL = 0;
    localparam int unsigned PATH_FLL = 1;
    localparam int unsigned PATH_USB_FIRC = 2;
    localparam int unsigned ST_PMODE_LSB = 0;
    localparam int unsigned ST_GMODE_LSB = 2;
    localparam int unsigned ST_REF_ERR = 8;
    localparam int unsigned ST_DIV_ERR = 9;
    localparam int unsigned ST_MODE_ERR = 10;
    localparam int unsigned ST_TRANS_ERR = 11;
    localparam int unsigned ST_FAULT = 12;
    localparam int unsigned ST_LOW_POWER_BOOT_OPTION = 16;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [5:0] SRCSEL_RST = 6'h00;
    localparam logic [3:0] DIV_RST = 4'h0;
    localparam logic [3:0] DIV_LOW_POWER_BOOT_OPTION = 4'h7;
    localparam logic [2:0] PATH_RST = 3'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PM_RUN = 2'b00,
        PM_VERY_LOW_POWER_RUN = 2'b01,
        PM_VERY_LOW_POWER_WAIT = 2'b10,
        PM_VERY_LOW_POWER_STOP = 2'b11
    } cgpol_pmode_t;

    typedef enum logic [2:0] {
        GM_FLL_INT = 3'b000,
        GM_FLL_EXT = 3'b001,
        GM_PLL_EXT = 3'b010,
        GM_BYP_LP_EXT = 3'b011,
        GM_BYP_LP_INT = 3'b100,
        GM_SLOW_IRC = 3'b101,
        GM_FAST_IRC = 3'b110
    } cgpol_gmode_t;
endpackage

// ### hw/cgpol_clk_gate.sv
/*
 * One glitch-free module clock gate: a half-rate clock whose enable only
 * takes effect while the output is low.
 * Assumes the shared system clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module cgpol_clk_gate (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic en,
    output logic clk_out
);
    logic clk_q;

    // Only a low output may start a new high phase, so no phase is cut short
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clk_q <= 1'b0;
        end else if (clk_q) begin
            clk_q <= 1'b0;
        end else begin
            clk_q <= en;
        end
    end

    assign clk_out = clk_q;
endmodule

// ### verif/cgpol_chk.sv
/*
 * Port checker for cgpol_top: access answers, gate clocks, power modes.
 * Assumes binding to cgpol_top and one clock with synchronous reset.
 */
`timescale 1ns/1ps
module cgpol_chk
    import cgpol_pkg::*;
#(
    parameter int unsigned LPO_HALF_CYCLES = LPO_HALF_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PERIPH_REQ,
    input wire logic [4:0] PERIPH_SEL,
    input wire logic PERIPH_ACK,
    input wire logic HARD_FAULT,
    input wire logic [NUM_GATES-1:0] MOD_CLK,
    input wire logic [2:0] GEN_MODE,
    input wire logic [3:0] CORE_DIV,
    input wire logic [3:0] BUS_DIV,
    input wire logic [1:0] PWR_MODE,
    input wire logic REG_ACTIVE,
    input wire logic FREQ_LIMIT,
    input wire logic LPO_CLK
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic [31:0] lpo_cnt_q;
    logic lpo_prev_q;
    // Cycles since the last low-power clock edge
    always_ff @(posedge CLK) begin
        lpo_prev_q <= LPO_CLK;
        if (!RST_N || LPO_CLK != lpo_prev_q) lpo_cnt_q <= 32'h0;
        else lpo_cnt_q <= lpo_cnt_q + 32'h1;
    end
    one_answer_a: assert property (PERIPH_REQ |=> PERIPH_ACK ^ HARD_FAULT)
        else $error("access not answered once");
    idle_quiet_a: assert property (!PERIPH_REQ |=> !(PERIPH_ACK || HARD_FAULT))
        else $error("answer without request");
    bad_index_a: assert property (PERIPH_REQ && PERIPH_SEL > 5'h1b |=> HARD_FAULT)
        else $error("bad index not faulted");
    gate_phase_a: assert property ((MOD_CLK & $past(MOD_CLK)) == '0)
        else $error("module clock high phase too long");
    reg_active_a: assert property (REG_ACTIVE == ($past(PWR_MODE) == 2'h0))
        else $error("regulation flag wrong");
    freq_limit_a: assert property (FREQ_LIMIT != REG_ACTIVE)
        else $error("limit flag wrong");
    vlp_gen_a: assert property (PWR_MODE inside {2'h1, 2'h2} |-> GEN_MODE inside {3'h3, 3'h4, 3'h5})
        else $error("generator mode illegal");
    div_lock_a: assert property (PWR_MODE != 2'h0 && $past(PWR_MODE) != 2'h0 |-> $stable({CORE_DIV, BUS_DIV}))
        else $error("divider changed in low power");
    wait_entry_a: assert property (PWR_MODE == 2'h2 && $past(PWR_MODE) != 2'h2 |-> $past(PWR_MODE) == 2'h1)
        else $error("wait entered from wrong mode");
    lpo_run_a: assert property (lpo_cnt_q <= LPO_HALF_CYCLES)
        else $error("low-power clock stalled");
endmodule

bind cgpol_top cgpol_chk #(.LPO_HALF_CYCLES(LPO_HALF_CYCLES)) i_chk (.*);

// ### verif/cgpol_periph.sv
/*
 * Peripheral side model: issues module accesses, counts module clock edges.
 * Assumes the bench pulses go for one cycle with the module index.
 */
`timescale 1ns/1ps
module cgpol_periph
    import cgpol_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NUM_GATES-1:0] mod_clk,
    input wire logic go,
    input wire logic [4:0] idx,
    output logic req,
    output logic [4:0] sel,
    output logic [7:0] ticks
);
    logic [4:0] mon_q;
    logic prev_q;
    // Released select lines keep changing so no stale index survives
    always_ff @(posedge clk) begin
        req <= go & rst_n;
        sel <= !rst_n ? 5'h0 : go ? idx : ~sel;
    end
    always_ff @(posedge clk) begin
        prev_q <= mod_clk[mon_q];
        if (!rst_n) begin
            mon_q <= 5'h0;
            ticks <= 8'h0;
        end else if (go) begin
            mon_q <= idx;
            ticks <= 8'h0;
        end else if (mod_clk[mon_q] && !prev_q) ticks <= ticks + 8'h1;
    end
endmodule

// ### verif/cgpol_top_tb.sv
/*
 * Self-checking bench for cgpol_top over AXI4-Lite and the access port.
 * Assumes cgpol_periph as the peripheral side and a 100 MHz clock.
 */
`timescale 1ns/1ps
module cgpol_top_tb
    import cgpol_pkg::*;
;
    logic CLK = 1'h0, RST_N = 1'h0, LOW_POWER_BOOT_OPTION_PIN = 1'h0, go = 1'h0;
    logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0, S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
    logic [31:0] S_AXI_AWADDR = 32'h0, S_AXI_WDATA = 32'h0, S_AXI_ARADDR = 32'h0;
    logic [3:0] S_AXI_WSTRB = 4'hf;
    logic [4:0] idx = 5'h0;
    wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, PERIPH_REQ, PERIPH_ACK, HARD_FAULT;
    wire PLL_REF_SEL, PLL_PATH_EN, FLL_PATH_EN, USB_FAST_IRC, REG_ACTIVE, FREQ_LIMIT, LPO_CLK;
    wire [1:0] S_AXI_BRESP, S_AXI_RRESP, FLL_REF_SEL, OUT_CLK_SEL, PWR_MODE;
    wire [31:0] S_AXI_RDATA;
    wire [4:0] PERIPH_SEL;
    wire [NUM_GATES-1:0] MOD_CLK;
    wire [2:0] GEN_MODE;
    wire [3:0] CORE_DIV, BUS_DIV;
    wire [7:0] ticks;
    int n_fail = 0, checks = 0;

    cgpol_top #(.LPO_HALF_CYCLES(4)) i_dut (.*);
    cgpol_periph i_per (.clk(CLK), .rst_n(RST_N), .mod_clk(MOD_CLK), .go(go), .idx(idx),
        .req(PERIPH_REQ), .sel(PERIPH_SEL), .ticks(ticks));
    always #5 CLK = ~CLK;

    // ------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int n);
        if (n >= 99) begin
            n_fail++;
            $display("[ERR] %0t wait got %h exp %h", $time, n, 0);
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        S_AXI_AWADDR <= {24'h0, a};
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'h1;
        S_AXI_WVALID <= 1'h1;
        S_AXI_BREADY <= 1'h1;
        for (n = 0; n < 99; n++) begin
            @(posedge CLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
            if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
            if (S_AXI_BVALID) break;
        end
        chk(S_AXI_BRESP, {a > OFS_STATUS || a[7:2] == 6'h7, 1'h0});
        S_AXI_BREADY <= 1'h0;
        tmo(n);
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge CLK);
        S_AXI_ARADDR <= {24'h0, a};
        S_AXI_ARVALID <= 1'h1;
        S_AXI_RREADY <= 1'h1;
        for (n = 0; n < 99; n++) begin
            @(posedge CLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
            if (S_AXI_RVALID) break;
        end
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'h0;
        tmo(n);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d & m, e);
    endtask
    task automatic acc(input logic [4:0] i, input logic f);
        @(posedge CLK);
        go <= 1'h1;
        idx <= i;
        @(posedge CLK);
        go <= 1'h0;
        repeat (2) @(posedge CLK);
        chk({HARD_FAULT, PERIPH_ACK}, {f, !f});
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_rst();
        logic [31:0] d;
        logic [1:0] r;
        for (int i = 0; i < 7; i++) rc(8'(i * 4), 32'hf, 32'(i == 6));
        rd(8'h40, d, r);
        chk({r, d[29:0]}, 32'h80000000);
        wr(8'h40, 32'h0);
        chk({PWR_MODE, REG_ACTIVE, FREQ_LIMIT}, 4'h2);
        $display("reset test done");
    endtask
    task automatic t_fault();
        acc(5'h0, 1'h1);
        wr(OFS_GATE0, 32'h1);
        acc(5'h0, 1'h0);
        acc(5'h18, 1'h0);
        acc(5'h1c, 1'h1);
        rc(OFS_STATUS, 32'h1000, 32'h1000);
        wr(OFS_STATUS, 32'h1f00);
        rc(OFS_STATUS, 32'h1f00, 32'h0);
        $display("fault test done");
    endtask
    task automatic t_gate();
        wr(OFS_GATE0, 32'h8);
        acc(5'h3, 1'h0);
        repeat (20) @(posedge CLK);
        chk(ticks >= 8'h8, 32'h1);
        wr(OFS_GATE0, 32'h0);
        acc(5'h3, 1'h1);
        repeat (10) @(posedge CLK);
        chk(ticks, 32'h0);
        $display("gate test done");
    endtask
    task automatic t_src();
        wr(OFS_SRCSEL, 32'h2);
        rc(OFS_STATUS, 32'h100, 32'h100);
        wr(OFS_SRCSEL, 32'h29);
        chk({PLL_REF_SEL, FLL_REF_SEL, OUT_CLK_SEL}, 32'h1a);
        wr(OFS_PATHCTL, 32'h7);
        wr(OFS_GENMODE, 32'h6);
        chk({PLL_PATH_EN, FLL_PATH_EN, USB_FAST_IRC, GEN_MODE}, 32'h3e);
        wr(OFS_STATUS, 32'h1f00);
        $display("source test done");
    endtask
    task automatic t_mode();
        wr(OFS_SYSDIV, 32'h21);
        chk({BUS_DIV, CORE_DIV}, 32'h21);
        wr(OFS_PMREQ, 32'h2);
        chk(PWR_MODE, 32'h0);
        rc(OFS_STATUS, 32'h800, 32'h800);
        wr(OFS_GENMODE, 32'h5);
        wr(OFS_PMREQ, 32'h1);
        chk(PWR_MODE, 32'h1);
        wr(OFS_SYSDIV, 32'h44);
        chk({BUS_DIV, CORE_DIV}, 32'h21);
        wr(OFS_GENMODE, 32'h0);
        chk(GEN_MODE, 32'h5);
        wr(OFS_GENMODE, 32'h3);
        chk(GEN_MODE, 32'h3);
        rc(OFS_STATUS, 32'h600, 32'h600);
        wr(OFS_PMREQ, 32'h2);
        chk(PWR_MODE, 32'h2);
        wr(OFS_PMREQ, 32'h1);
        wr(OFS_PMREQ, 32'h0);
        wr(OFS_PMREQ, 32'h3);
        chk(PWR_MODE, 32'h3);
        wr(OFS_PMREQ, 32'h1);
        chk(PWR_MODE, 32'h3);
        wr(OFS_PMREQ, 32'h0);
        chk(PWR_MODE, 32'h0);
        $display("mode test done");
    endtask
    task automatic t_boot();
        @(posedge CLK);
        RST_N <= 1'h0;
        LOW_POWER_BOOT_OPTION_PIN <= 1'h1;
        repeat (16) @(posedge CLK);
        RST_N <= 1'h1;
        repeat (6) @(posedge CLK);
        chk({PWR_MODE, GEN_MODE, CORE_DIV, BUS_DIV}, {19'h0, 2'h1, 3'h5, 8'h77});
        rc(OFS_STATUS, 32'h10000, 32'h10000);
        rc(OFS_GATE0, 32'hf, 32'h0);
        $display("boot test done");
    endtask

    initial begin
        repeat (16) @(posedge CLK);
        RST_N <= 1'h1;
        t_rst();
        t_fault();
        t_gate();
        t_src();
        t_mode();
        t_boot();
        stop_test();
    end
endmodule
